/* core/token_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Flags active low; write zero claims, one frees.
// - Token select low; other pins as SRAM access.
// - Claim by writing zero, then read back.
// - Failed claim: keep reading or write one.
// - Write one to all tokens at start.
// - No access within guard times around sleep.
// - Token access: primary enable high, secondary low.
module token_host (
  input  wire logic                             mclk_i,     // Clock
  input  wire logic                             nrst_i,     // Reset
  input  wire logic                             cmd_valid_i, // Request
  input  wire token_host_pkg::op_t              cmd_op_i,   // Operation
  input  wire logic [token_host_pkg::IDX_W-1:0] cmd_idx_i,  // Token number
  input  wire logic                             cmd_spin_i, // Retry reads
  input  wire logic                             sleep_i,    // Want sleep
  input  wire logic [token_host_pkg::DQ_W-1:0]  dq_i,       // Data pins in
  output logic                                  cmd_ready_o, // Can take
  output logic                                  done_o,     // Op finished
  output logic                                  granted_o,  // Owned at last read
  output logic                                  flag_o,     // Last flag
  output logic                                  asleep_o,   // Port asleep
  output token_host_pkg::pins_t                 pins_o      // Port pins
);
  token_host_pkg::ctl_t q;
  token_host_pkg::ctl_t next_q;

  // ----------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    case (q.st)
      token_host_pkg::ST_IDLE: begin
        if (sleep_i) begin
          next_q.st  = token_host_pkg::ST_DOZE;
          next_q.cnt = token_host_pkg::DOZE_LOAD;
        end else if (cmd_valid_i) begin
          next_q.st   = token_host_pkg::ST_SETUP;
          next_q.op   = cmd_op_i;
          next_q.idx  = cmd_idx_i;
          next_q.spin = cmd_spin_i;
          // Claim always starts with the write, never a read
          next_q.wr   = (cmd_op_i != token_host_pkg::OP_TEST);
          next_q.wbit = (cmd_op_i == token_host_pkg::OP_FREE);
        end
      end
      token_host_pkg::ST_SETUP: begin
        next_q.st  = token_host_pkg::ST_STROBE;
        next_q.cnt = token_host_pkg::STROBE_LOAD;
      end
      token_host_pkg::ST_STROBE: begin
        if (q.cnt == '0) begin
          next_q.st = token_host_pkg::ST_RECOV;
          if (!q.wr) begin
            next_q.flag = dq_i[0];
          end
        end else begin
          next_q.cnt = q.cnt - 1'b1;
        end
      end
      token_host_pkg::ST_RECOV: begin
        next_q.st = token_host_pkg::ST_IDLE;
        if (q.init) begin
          // Free every token after reset, left to right
          if (q.idx == token_host_pkg::LAST_IDX) begin
            next_q.init = 1'b0;
          end else begin
            next_q.idx = q.idx + 1'b1;
            next_q.st  = token_host_pkg::ST_SETUP;
          end
        end else if (q.op == token_host_pkg::OP_CLAIM && q.wr && !q.wbit) begin
          next_q.st = token_host_pkg::ST_SETUP;
          next_q.wr = 1'b0;
        end else if (q.op == token_host_pkg::OP_CLAIM && !q.wr && q.flag) begin
          // A forgotten zero would seize the token later
          next_q.st = token_host_pkg::ST_SETUP;
          if (!q.spin) begin
            next_q.wr   = 1'b1;
            next_q.wbit = 1'b1;
          end
        end else begin
          next_q.done = 1'b1;
        end
      end
      token_host_pkg::ST_DOZE: begin
        if (q.cnt == '0) begin
          next_q.st = token_host_pkg::ST_SLEEP;
        end else begin
          next_q.cnt = q.cnt - 1'b1;
        end
      end
      token_host_pkg::ST_SLEEP: begin
        if (!sleep_i) begin
          next_q.st  = token_host_pkg::ST_WAKE;
          next_q.cnt = token_host_pkg::WAKE_LOAD;
        end
      end
      token_host_pkg::ST_WAKE: begin
        if (q.cnt == '0) begin
          next_q.st = token_host_pkg::ST_IDLE;
        end else begin
          next_q.cnt = q.cnt - 1'b1;
        end
      end
      default: begin
        next_q.st = token_host_pkg::ST_IDLE;
      end
    endcase

    // --------------------------------------------------------
    // Pin drive, registered from the next state
    // --------------------------------------------------------
    next_q.pins = token_host_pkg::PINS_RST;
    next_q.pins.low_power_request =
      (next_q.st == token_host_pkg::ST_SLEEP);
    if (next_q.st == token_host_pkg::ST_SETUP ||
        next_q.st == token_host_pkg::ST_STROBE) begin
      next_q.pins.token_space_select_n  = 1'b0;
      next_q.pins.primary_chip_enable_n = 1'b1;
      next_q.pins.secondary_chip_enable = 1'b0;
      next_q.pins.byte_lane_enable_n    = '0;
      next_q.pins.idx     = next_q.idx;
      next_q.pins.dq      = {token_host_pkg::DQ_W{next_q.wbit}};
      next_q.pins.dq_oe_n = !next_q.wr;
      if (next_q.st == token_host_pkg::ST_STROBE) begin
        next_q.pins.rw   = !next_q.wr;
        next_q.pins.oe_n = next_q.wr;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= token_host_pkg::CTL_RST;
    end else begin
      q <= next_q;
    end
  end

  assign cmd_ready_o = (q.st == token_host_pkg::ST_IDLE) && !sleep_i;
  assign done_o      = q.done;
  assign granted_o   = !q.flag;
  assign flag_o      = q.flag;
  assign asleep_o    = q.pins.low_power_request;
  assign pins_o      = q.pins;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_claim_wr;
    q.st == token_host_pkg::ST_STROBE && q.op == token_host_pkg::OP_CLAIM
      && q.wr && !q.wbit && !q.init;
  endsequence
  sequence s_read_setup;
    q.st == token_host_pkg::ST_SETUP && !q.wr;
  endsequence

  a_token_select: assert property (
    !pins_o.token_space_select_n |->
      pins_o.primary_chip_enable_n && !pins_o.secondary_chip_enable)
    else $error("token access with main array selected");
  a_read_enables: assert property (
    !pins_o.oe_n |-> !pins_o.token_space_select_n && pins_o.rw
      && pins_o.byte_lane_enable_n == '0)
    else $error("read strobe without select or byte enables");
  a_write_drive: assert property (
    !pins_o.rw |-> !pins_o.dq_oe_n && pins_o.oe_n
      && !pins_o.token_space_select_n)
    else $error("write strobe without data drive");
  a_write_width: assert property (
    $fell(pins_o.rw) |=> !pins_o.rw)
    else $error("write strobe shorter than two cycles");
  a_claim_order: assert property (
    s_claim_wr ##1 q.st == token_host_pkg::ST_RECOV |=> s_read_setup)
    else $error("claim write not followed by read back");
  a_fail_withdraw: assert property (
    q.st == token_host_pkg::ST_RECOV && q.op == token_host_pkg::OP_CLAIM
      && !q.wr && q.flag && !q.spin && !q.init
    |=> q.st == token_host_pkg::ST_SETUP && q.wr && q.wbit)
    else $error("failed claim left pending");
  a_withdraw_done: assert property (
    q.st == token_host_pkg::ST_RECOV && q.op == token_host_pkg::OP_CLAIM
      && q.wr && q.wbit && !q.init
    |=> done_o && !granted_o)
    else $error("withdrawn claim not reported as lost");
  a_init_free: assert property (
    q.init && !pins_o.rw |-> pins_o.dq[0])
    else $error("start-up write is not a release");
  a_sleep_guard: assert property (
    !pins_o.token_space_select_n |-> ##1 (!pins_o.low_power_request)[*4])
    else $error("sleep raised inside guard time");
  a_wake_guard: assert property (
    $fell(pins_o.low_power_request) |-> pins_o.token_space_select_n[*4])
    else $error("access inside wake guard time");
  a_sleep_quiet: assert property (
    pins_o.low_power_request |-> pins_o.token_space_select_n
      && pins_o.rw && pins_o.oe_n)
    else $error("access while port asleep");
  a_claim_done: assert property (
    q.st == token_host_pkg::ST_STROBE && q.cnt == '0 && !q.wr && !q.init
      && q.op == token_host_pkg::OP_CLAIM && !dq_i[0]
    |-> ##2 done_o && granted_o)
    else $error("won claim not reported");
endmodule
`default_nettype wire

/* include/token_host_pkg.sv */
`default_nettype none
package token_host_pkg;
  // ----------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------
  localparam int unsigned IDX_W     = 3;
  localparam int unsigned DQ_W      = 18;
  localparam int unsigned BE_W      = 2;
  localparam int unsigned CNT_W     = 8;
  localparam int unsigned CLK_NS    = 25;
  localparam int unsigned STROBE_NS = 40;
  localparam int unsigned DOZE_NS   = 100;
  localparam int unsigned WAKE_NS   = 100;
  // Least times, rounded up to whole cycles
  localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DOZE_CYC   = (DOZE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WAKE_CYC   = (WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [CNT_W-1:0] STROBE_LOAD = CNT_W'(STROBE_CYC - 1);
  localparam logic [CNT_W-1:0] DOZE_LOAD   = CNT_W'(DOZE_CYC - 1);
  localparam logic [CNT_W-1:0] WAKE_LOAD   = CNT_W'(WAKE_CYC - 1);
  localparam logic [IDX_W-1:0] LAST_IDX    = 3'h7;

  // ----------------------------------------------------------
  // Types
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    OP_CLAIM = 2'h0,
    OP_FREE  = 2'h1,
    OP_TEST  = 2'h2
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SETUP  = 3'h1,
    ST_STROBE = 3'h2,
    ST_RECOV  = 3'h3,
    ST_DOZE   = 3'h4,
    ST_SLEEP  = 3'h5,
    ST_WAKE   = 3'h6
  } st_t;

  typedef struct packed {
    logic             low_power_request;
    logic             token_space_select_n;
    logic             primary_chip_enable_n;
    logic             secondary_chip_enable;
    logic             rw;
    logic             oe_n;
    logic [BE_W-1:0]  byte_lane_enable_n;
    logic [IDX_W-1:0] idx;
    logic [DQ_W-1:0]  dq;
    logic             dq_oe_n;
  } pins_t;

  typedef struct packed {
    st_t              st;
    op_t              op;
    logic             init;
    logic             wr;
    logic             wbit;
    logic             spin;
    logic             flag;
    logic             done;
    logic [IDX_W-1:0] idx;
    logic [CNT_W-1:0] cnt;
    pins_t            pins;
  } ctl_t;

  localparam pins_t PINS_RST = '{low_power_request: 1'b0,
    token_space_select_n: 1'b1, primary_chip_enable_n: 1'b1,
    secondary_chip_enable: 1'b0, rw: 1'b1, oe_n: 1'b1,
    byte_lane_enable_n: 2'h3, idx: 3'h0, dq: 18'h0, dq_oe_n: 1'b1};
  localparam ctl_t CTL_RST = '{st: ST_SETUP, op: OP_FREE, init: 1'b1,
    wr: 1'b1, wbit: 1'b1, spin: 1'b0, flag: 1'b1, done: 1'b0,
    idx: 3'h0, cnt: 8'h0, pins: PINS_RST};
endpackage
`default_nettype wire

/* testbench/token_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------
// Device side: eight tokens, host is the left
// ----------------------------------------------
module token_dev_model (
  input  wire token_host_pkg::pins_t p_i,  // Host pins
  input  wire logic                  ow_i, // Far side write strobe
  input  wire logic [2:0]            oi_i, // Far side token
  input  wire logic                  ob_i, // Far side bit
  output logic [17:0]                dq_o  // Data to host
);
  logic [7:0]  rl = 8'h0;      // Request latches, host side
  logic [7:0]  rr = 8'h0;      // Request latches, far side
  logic [1:0]  own [8];        // 0 free, 1 host, 2 far
  logic [17:0] dq = 18'h2aaaa;
  wire sel = !p_i.token_space_select_n && p_i.primary_chip_enable_n
    && !p_i.secondary_chip_enable
    && !p_i.low_power_request;
  wire rd  = sel && p_i.rw && !p_i.oe_n
    && p_i.byte_lane_enable_n != 2'h3;
  wire wr  = sel && !p_i.rw && !p_i.dq_oe_n;
  // Not cleared at power-up: worst case is a stale host claim
  initial foreach (own[i]) own[i] = 2'h1;
  function automatic void settle(input int i);
    if (own[i] == 2'h1 && rl[i]) own[i] = rr[i] ? 2'h0 : 2'h2;
    else if (own[i] == 2'h2 && rr[i]) own[i] = rl[i] ? 2'h0 : 2'h1;
    // Host wins a dead heat
    if (own[i] == 2'h0) own[i] = !rl[i] ? 2'h1 : !rr[i] ? 2'h2 : 2'h0;
  endfunction
  always @(posedge wr) begin
    rl[p_i.idx] = p_i.dq[0];
    settle(p_i.idx);
  end
  always @(posedge ow_i) begin
    rr[oi_i] = ob_i;
    settle(oi_i);
  end
  // Latched at read start, so far-side writes cannot tear it
  always @(posedge rd) dq = {18{own[p_i.idx] != 2'h1}};
  always @(negedge rd) dq = ~dq;
  assign dq_o = dq;
endmodule
`default_nettype wire

/* testbench/dual_port_token_semaphores_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------
// Bench
// ----------------------------------------------
module dual_port_token_semaphores_tb_top;
  localparam token_host_pkg::op_t CL = token_host_pkg::OP_CLAIM;
  localparam token_host_pkg::op_t FR = token_host_pkg::OP_FREE;
  localparam token_host_pkg::op_t TS = token_host_pkg::OP_TEST;
  logic mclk_i = 1'b0, nrst_i = 1'b0, valid = 1'b0, spin = 1'b0;
  logic slp = 1'b0, ow = 1'b0, ob = 1'b1;
  token_host_pkg::op_t op = TS;
  logic [2:0] idx = 3'h0, oi = 3'h0, k3;
  logic [17:0] dq;
  logic rdy, done, gr, flag, asl;
  token_host_pkg::pins_t pins;
  wire [1:0] en_pins = {pins.primary_chip_enable_n,
                        pins.secondary_chip_enable};
  logic [1:0] expq [$]; // Bit 1: flag checked, bit 0: flag
  int err_total = 0, checks_done = 0, cyc = 0, seed = 67, k;
  always #12.5 mclk_i = ~mclk_i;
  token_host dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .cmd_valid_i(valid),
    .cmd_op_i(op), .cmd_idx_i(idx), .cmd_spin_i(spin), .sleep_i(slp),
    .dq_i(dq), .cmd_ready_o(rdy), .done_o(done), .granted_o(gr),
    .flag_o(flag), .asleep_o(asl), .pins_o(pins));
  token_dev_model dev (.p_i(pins), .ow_i(ow), .oi_i(oi), .ob_i(ob),
    .dq_o(dq));
  task automatic chk(input string nm, input logic [17:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmd(input token_host_pkg::op_t o, input logic [2:0] i,
                     input logic s, input logic [1:0] e);
    int n;
    n = 0;
    @(negedge mclk_i);
    while (rdy !== 1'b1 && n < 200) begin
      @(negedge mclk_i);
      n++;
    end
    op = o;
    idx = i;
    spin = s;
    valid = 1'b1;
    expq.push_back(e);
    @(negedge mclk_i);
    valid = 1'b0;
    idx = 3'($random(seed)); // Idle noise must be ignored
    while (done !== 1'b1 && n < 400) begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 400) begin
      err_total++;
      give_verdict();
    end
  endtask
  task automatic other(input logic [2:0] i, input logic b);
    @(negedge mclk_i);
    oi = i;
    ob = b;
    ow = 1'b1;
    @(negedge mclk_i);
    ow = 1'b0;
  endtask
  always @(posedge mclk_i) begin
    #1;
    if (pins.token_space_select_n === 1'b0) begin
      chk("enables", 18'(en_pins), 18'h2);
    end
    if (done === 1'b1 && expq.size() == 0) begin
      chk("spare_done", 18'h1, 18'h0);
    end
    if (done === 1'b1 && expq.size() > 0) begin
      if (expq[0][1]) begin
        chk("flag_o", 18'(flag), 18'(expq[0][0]));
        chk("granted_o", 18'(gr), 18'(!expq[0][0]));
      end
      void'(expq.pop_front());
    end
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    for (k = 0; k < 8; k++) other(3'(k), 1'b1); // Far side frees all
    repeat (4) @(negedge mclk_i);
    nrst_i = 1'b1;
    for (k = 0; k < 8; k++) cmd(TS, 3'(k), 1'b0, 2'h3);
    k3 = 3'($random(seed));
    cmd(CL, k3, 1'b0, 2'h2);
    other(k3, 1'b0);
    cmd(TS, k3, 1'b0, 2'h2);
    cmd(FR, k3, 1'b0, 2'h0);
    cmd(TS, k3, 1'b0, 2'h3);
    cmd(CL, k3, 1'b0, 2'h3);
    other(k3, 1'b1);
    cmd(TS, k3, 1'b0, 2'h3);
    other(k3, 1'b0);
    fork
      cmd(CL, k3, 1'b1, 2'h2);
      begin
        repeat (40) @(negedge mclk_i);
        other(k3, 1'b1);
      end
    join
    cmd(FR, k3, 1'b0, 2'h0);
    for (k = 0; k < 6; k++) begin
      k3 = 3'($random(seed));
      cmd(CL, k3, 1'b0, 2'h2);
      cmd(FR, k3, 1'b0, 2'h0);
    end
    @(negedge mclk_i);
    slp = 1'b1;
    repeat (12) @(negedge mclk_i);
    chk("asleep", 18'({asl, pins.low_power_request}), 18'h3);
    chk("quiet", 18'({pins.token_space_select_n, rdy}), 18'h2);
    slp = 1'b0;
    cmd(TS, 3'h0, 1'b0, 2'h3);
    repeat (8) @(negedge mclk_i);
    chk("left_over", 18'(expq.size()), 18'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
